//--- eiop_pkg.sv
/*
 * eiop_pkg: constants and types shared by the eight-bit i/o port three.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package eiop_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADR_W  = 18;
    localparam int unsigned IDX_W  = 16;
    localparam int unsigned DAT_W  = 32;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_LATCH = 16'h7f4c;
    localparam logic [15:0] IDX_INPUT = 16'h7f4d;
    localparam logic [15:0] IDX_DIR   = 16'h7f4e;
    localparam logic [15:0] IDX_FSA   = 16'h7f4f;
    localparam logic [15:0] IDX_FSB   = 16'h7ff3;

    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR   = 8'h00;
    localparam logic [7:0] RST_FSA   = 8'h00;
    localparam logic [7:0] RST_FSB   = 8'h00;
    localparam logic [7:0] RST_OE_N  = 8'hff;
    localparam logic [7:0] RST_ZERO  = 8'h00;
    localparam logic [7:0] RD_NONE   = 8'h00;

    localparam int unsigned PIN_RX    = 4;
    localparam int unsigned PIN_ALT_LO = 5;

    // function select pair {a, b}
    typedef enum logic [1:0] {
        FS_STD,
        FS_SLOW,
        FS_LEVEL,
        FS_ALT
    } eiop_fs_type;
endpackage

//--- eiop_sync.sv
/*
 * eiop_sync: three-stage input synchroniser with agreement filter.
 * Assumes asynchronous inputs; output changes once stages two and three agree.
 */
`timescale 1ns/1ns
module eiop_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         ref_clk, // system clock
    input  wire logic         sys_rst, // async reset, high
    input  wire logic [W-1:0] d_in,    // raw asynchronous input
    output logic      [W-1:0] q_out    // filtered synchronous level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } eiop_sync_type;

    eiop_sync_type s_r;
    eiop_sync_type s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = d_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        for (int i = 0; i < W; i++) begin
            if (s_r.s2[i] == s_r.s3[i]) begin
                s_nxt.q[i] = s_r.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.q;
endmodule

//--- eiop_pin_cell.sv
/*
 * eiop_pin_cell: decodes one pin's four control bits into drive state.
 * Assumes the caller registers the outputs; purely combinational.
 */
`timescale 1ns/1ns
module eiop_pin_cell #(
    parameter bit ALT_EN = 1'b0
) (
    input  wire logic fsa,     // function select a bit
    input  wire logic fsb,     // function select b bit
    input  wire logic lat,     // output latch bit
    input  wire logic ddr,     // direction bit
    input  wire logic alt_in,  // alternate function output level
    output logic      drive_o, // level driven when enabled
    output logic      oe_n,    // low while driving
    output logic      pull_up, // pull-up enable
    output logic      slow,    // slow edge enable
    output logic      inv      // invert input read
);
    logic en;

    always_comb begin
        en      = 1'b0;
        drive_o = 1'b0;
        pull_up = 1'b0;
        slow    = 1'b0;
        inv     = 1'b0;
        unique case (eiop_pkg::eiop_fs_type'({fsa, fsb}))
            eiop_pkg::FS_STD: begin
                if (ddr) begin
                    en      = 1'b1;
                    drive_o = lat;
                end else begin
                    pull_up = lat;
                end
            end
            eiop_pkg::FS_SLOW: begin
                if (!ddr) begin
                    en      = 1'b1;
                    drive_o = lat;
                    slow    = 1'b1;
                end else if (!lat) begin
                    en = 1'b1;
                end else begin
                    inv = 1'b1;
                end
            end
            eiop_pkg::FS_LEVEL: begin
                en  = 1'b1;
                inv = lat & ~ddr;
                if (ALT_EN && (lat ^ ddr)) begin
                    drive_o = ddr ? alt_in : ~alt_in;
                end else begin
                    drive_o = ddr;
                end
            end
            eiop_pkg::FS_ALT: begin
                if (!ddr) begin
                    en      = 1'b1;
                    slow    = 1'b1;
                    drive_o = ALT_EN ? (lat & alt_in) : lat;
                end else if (ALT_EN && !lat) begin
                    en = ~alt_in; // alternate open drain
                end
            end
        endcase
        oe_n = ~en;
    end
endmodule

//--- eiop_port.sv
/*
 * eiop_port: eight-bit general-purpose i/o port three with Wishbone registers.
 * Assumes a classic Wishbone master on ref_clk and pad logic that resolves
 * pin_o / pin_oe_n / pin_pull_up into the wire and returns it on pin_i.
 */
// Design decision made here: register access over Wishbone.
// Notes on behaviour
// - eight two-way pins, each with its own direction bit.
// - output latch is 8-bit read/write, gives output level and pull-up, resets to zero.
// - direction register is 8-bit read/write, one bit per pin, resets to zero.
// - a read-only input address returns the live level of all eight pins.
// - the input read shows pin levels whatever the direction, so driven pins read back.
// - pins set for inverted input read back complemented.
// - function select a and b are 8-bit read/write, reset to zero, and choose the mode.
// - selects 00: dir 0 latch 0 floats, dir 0 latch 1 pulls up, dir 1 drives the latch.
// - selects 01: dir 0 drives latch slowly, dir 1 latch 0 low, dir 1 latch 1 floats inverted.
// - selects 10: pin drives the direction bit (pins 5 to 7: alternate level if latch and dir differ, inverted for dir 0), latch 1 with dir 0 inverts the read.
// - selects 11: dir 0 drives latch slowly (pins 5 to 7: latch AND alternate), dir 1 floats (pins 5 to 7 latch 0: alternate open drain).
// - pin levels always reach the on-chip inputs, interrupt inputs inverted with the read.
// - pins 0 to 3 are the four external interrupt request inputs.
// - pins 4 and 5 serve the third serial channel.
// - pin 6 can carry timer six output and pin 7 timer seven output.
`timescale 1ns/1ns
module eiop_port (
    input  wire logic        ref_clk,           // 50 MHz system clock
    input  wire logic        sys_rst,           // async reset, high
    input  wire logic        wb_cyc_i,          // bus cycle
    input  wire logic        wb_stb_i,          // strobe
    input  wire logic        wb_we_i,           // write enable
    input  wire logic [17:0] wb_adr_i,          // byte address
    input  wire logic [3:0]  wb_sel_i,          // byte selects
    input  wire logic [31:0] wb_dat_i,          // write data
    output logic      [31:0] wb_dat_o,          // read data
    output logic             wb_ack_o,          // acknowledge
    input  wire logic [7:0]  pin_i,             // pad levels
    output logic      [7:0]  pin_o,             // pad drive levels
    output logic      [7:0]  pin_oe_n,          // pad enables, low drives
    output logic      [7:0]  pin_pull_up,       // pull-up enables
    output logic      [7:0]  pin_slow,          // slow edge enables
    output logic      [7:0]  pin_level,         // pin levels to on-chip users
    output logic             ext_irq_zero,      // interrupt request 0
    output logic             ext_irq_one,       // interrupt request 1
    output logic             ext_irq_two,       // interrupt request 2
    output logic             ext_irq_three,     // interrupt request 3
    output logic             serial_rx,         // third serial channel receive
    input  wire logic        serial_tx,         // third serial channel transmit
    input  wire logic        timer_six_out,     // timer six output
    input  wire logic        timer_seven_out    // timer seven output
);
    typedef struct packed {
        logic [7:0] lat;
        logic [7:0] ddr;
        logic [7:0] fsa;
        logic [7:0] fsb;
        logic       ack;
        logic [7:0] rdat;
        logic [7:0] pin_o;
        logic [7:0] oe_n;
        logic [7:0] pull;
        logic [7:0] slow;
        logic [7:0] level;
        logic [3:0] irq;
        logic       rx;
    } eiop_port_type;

    eiop_port_type s_r;
    eiop_port_type s_nxt;

    logic [7:0]  filt;
    logic [7:0]  drive;
    logic [7:0]  oe_n_c;
    logic [7:0]  pull_c;
    logic [7:0]  slow_c;
    logic [7:0]  inv_c;
    logic [7:0]  alt_in;
    logic [7:0]  rd_input;
    logic [15:0] idx;
    logic        wr_go;

    eiop_sync #(
        .W       (eiop_pkg::PORT_W)
    ) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .d_in    (pin_i),
        .q_out   (filt)
    );

    assign alt_in = {timer_seven_out, timer_six_out, serial_tx, 5'h00};

    for (genvar g = 0; g < 8; g++) begin : g_cell
        eiop_pin_cell #(
            .ALT_EN  (g >= eiop_pkg::PIN_ALT_LO)
        ) u_cell (
            .fsa     (s_r.fsa[g]),
            .fsb     (s_r.fsb[g]),
            .lat     (s_r.lat[g]),
            .ddr     (s_r.ddr[g]),
            .alt_in  (alt_in[g]),
            .drive_o (drive[g]),
            .oe_n    (oe_n_c[g]),
            .pull_up (pull_c[g]),
            .slow    (slow_c[g]),
            .inv     (inv_c[g])
        );
    end

    assign idx      = wb_adr_i[17:2];
    assign rd_input = filt ^ inv_c;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
        wr_go     = s_nxt.ack & wb_we_i & wb_sel_i[0];
        if (s_nxt.ack) begin
            unique case (idx)
                eiop_pkg::IDX_LATCH: s_nxt.rdat = s_r.lat;
                eiop_pkg::IDX_INPUT: s_nxt.rdat = rd_input;
                eiop_pkg::IDX_DIR:   s_nxt.rdat = s_r.ddr;
                eiop_pkg::IDX_FSA:   s_nxt.rdat = s_r.fsa;
                eiop_pkg::IDX_FSB:   s_nxt.rdat = s_r.fsb;
                default:             s_nxt.rdat = eiop_pkg::RD_NONE;
            endcase
        end
        if (wr_go) begin
            unique case (idx)
                eiop_pkg::IDX_LATCH: s_nxt.lat = wb_dat_i[7:0];
                eiop_pkg::IDX_DIR:   s_nxt.ddr = wb_dat_i[7:0];
                eiop_pkg::IDX_FSA:   s_nxt.fsa = wb_dat_i[7:0];
                eiop_pkg::IDX_FSB:   s_nxt.fsb = wb_dat_i[7:0];
                default:             s_nxt.lat = s_r.lat;
            endcase
        end
        // pad state follows registers one cycle later
        s_nxt.pin_o = drive;
        s_nxt.oe_n  = oe_n_c;
        s_nxt.pull  = pull_c;
        s_nxt.slow  = slow_c;
        s_nxt.level = filt;
        s_nxt.irq   = rd_input[3:0];
        s_nxt.rx    = filt[eiop_pkg::PIN_RX];
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r       <= '0;
            s_r.lat   <= eiop_pkg::RST_LATCH;
            s_r.ddr   <= eiop_pkg::RST_DIR;
            s_r.fsa   <= eiop_pkg::RST_FSA;
            s_r.fsb   <= eiop_pkg::RST_FSB;
            s_r.oe_n  <= eiop_pkg::RST_OE_N;
            s_r.pin_o <= eiop_pkg::RST_ZERO;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o      = {24'h000000, s_r.rdat};
    assign wb_ack_o      = s_r.ack;
    assign pin_o         = s_r.pin_o;
    assign pin_oe_n      = s_r.oe_n;
    assign pin_pull_up   = s_r.pull;
    assign pin_slow      = s_r.slow;
    assign pin_level     = s_r.level;
    assign ext_irq_zero  = s_r.irq[0];
    assign ext_irq_one   = s_r.irq[1];
    assign ext_irq_two   = s_r.irq[2];
    assign ext_irq_three = s_r.irq[3];
    assign serial_rx     = s_r.rx;
endmodule

//--- eiop_port_monitor.sv
/* eiop_port_monitor: bus and pad checks on the port's own pins.
   Assumes binding onto eiop_port; sees its ports only. */
`timescale 1ns/1ns
module eiop_port_monitor (
    input wire logic        ref_clk,     // system clock
    input wire logic        sys_rst,     // async reset, high
    input wire logic        wb_cyc_i,    // bus cycle
    input wire logic        wb_stb_i,    // strobe
    input wire logic [31:0] wb_dat_o,    // read data
    input wire logic        wb_ack_o,    // acknowledge
    input wire logic [7:0]  pin_i,       // pad levels
    input wire logic [7:0]  pin_oe_n,    // pad enables
    input wire logic [7:0]  pin_pull_up, // pull-up enables
    input wire logic [7:0]  pin_slow,    // slow edge enables
    input wire logic [7:0]  pin_level,   // filtered levels
    input wire logic        serial_rx    // serial receive
);
    logic [3:0] up_cnt; // cycles since reset, saturating
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_cnt <= 4'h0;
        end else if (up_cnt != 4'hf) begin
            up_cnt <= up_cnt + 4'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    a_pull_not_driven: assert property ((pin_pull_up & ~pin_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    a_slow_driven: assert property ((pin_slow & pin_oe_n) == 8'h00)
        else $error("slow edges on an undriven pin");
    a_reset_idle: assert property ($past(sys_rst) |-> pin_oe_n == 8'hff && pin_pull_up == 8'h00)
        else $error("pins not idle after reset");
    a_level_follows: assert property ((up_cnt == 4'hf && $stable(pin_i[0])) [*6] |-> pin_level[0] == pin_i[0])
        else $error("pin level not forwarded");
    a_serial_rx_pin: assert property (serial_rx == pin_level[4])
        else $error("serial receive differs from pin four");
endmodule

//--- eiop_pads.sv
/* eiop_pads: board model at the port pins.
   Assumes the bench drives ext_en only where the port leaves a pin undriven. */
`timescale 1ns/1ns
module eiop_pads (
    input  wire logic       ref_clk,     // clock for float pattern
    input  wire logic [7:0] pin_o,       // port drive level
    input  wire logic [7:0] pin_oe_n,    // low while port drives
    input  wire logic [7:0] pin_pull_up, // pull-up enables
    input  wire logic [7:0] ext_en,      // board drives pin
    input  wire logic [7:0] ext_val,     // board drive level
    output logic      [7:0] pin_i        // resolved pin level
);
    logic [7:0] flt = 8'h55; // undriven pins wander
    always @(posedge ref_clk) flt <= ~flt;
    assign pin_i = (~pin_oe_n & pin_o)
                 | (pin_oe_n & ext_en & ext_val)
                 | (pin_oe_n & ~ext_en & (pin_pull_up | flt));
endmodule

//--- eiop_port_tb.sv
/* eiop_port_tb: register and pin-mode test of the port, random with fixed seed.
   Assumes eiop_pads as the board and a 50 MHz ref_clk. */
`timescale 1ns/1ns
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", nm, e, a); end end
module eiop_port_tb;
    logic        ref_clk = 1'h0, sys_rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic        tx = 1'h0, t6 = 1'h0, t7 = 1'h0, ack, rx;
    logic [17:0] adr = 18'h00000;
    logic [3:0]  sel = 4'h0;
    wire   [3:0]  irq;
    logic [2:0]  ta;
    logic [31:0] wdat = 32'h00000000, rdat;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00, p_i, p_o, oe_n, pu, sl, lvl, q, k, av, w;
    logic [7:0]  e_oe, e_o, e_pu, e_sl, e_iv, v [4];
    logic [15:0] idx [4] = '{eiop_pkg::IDX_LATCH, eiop_pkg::IDX_DIR, eiop_pkg::IDX_FSA, eiop_pkg::IDX_FSB};
    int          n_fail = 0, check_count = 0;
    always #10 ref_clk = ~ref_clk;
    eiop_port dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(p_i),
        .pin_o(p_o), .pin_oe_n(oe_n), .pin_pull_up(pu), .pin_slow(sl), .pin_level(lvl), .ext_irq_zero(irq[0]),
        .ext_irq_one(irq[1]), .ext_irq_two(irq[2]), .ext_irq_three(irq[3]), .serial_rx(rx), .serial_tx(tx),
        .timer_six_out(t6), .timer_seven_out(t7));
    eiop_pads pads_u (.ref_clk(ref_clk), .pin_o(p_o), .pin_oe_n(oe_n), .pin_pull_up(pu), .ext_en(ext_en),
        .ext_val(ext_val), .pin_i(p_i));
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wb(input logic wr, input logic [15:0] ix, input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] rd);
        int n;
        @(posedge ref_clk);
        {cyc, stb, we, sel} <= {2'h3, wr, s};
        adr <= {ix, 2'h0};
        wdat <= {24'h000000, d};
        n = 0;
        do begin @(posedge ref_clk); n++; end while (ack !== 1'h1 && n < 20);
        if (n >= 20) begin n_fail++; give_verdict(); end
        rd = rdat[7:0];
        {cyc, stb} <= 2'h0;
    endtask
    // per-pin decode of {fsa, fsb, latch, dir}, alternate flag x and level a into {oe_n, drive, pull, slow, invert}
    function automatic logic [4:0] dec(input logic [3:0] c, input logic x, input logic a);
        case (c[3:2])
            2'h0: return c[0] ? {1'h0, c[1], 3'h0} : {1'h1, 1'h0, c[1], 2'h0};
            2'h1: return !c[0] ? {1'h0, c[1], 3'h2} : {c[1], 3'h0, c[1]};
            2'h2: return {1'h0, (x && c[1] != c[0]) ? (c[0] ? a : !a) : c[0], 2'h0, c[1] & !c[0]};
            default: return c[0] ? ((x && !c[1]) ? {a, 4'h0} : 5'h10) : {1'h0, c[1] & (a | !x), 3'h2};
        endcase
    endfunction
    initial begin
        void'($urandom(51));
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'h0;
        for (int j = 0; j < 4; j++) begin
            wb(1'h0, idx[j], 8'h00, 4'h1, q);
            `CHK("reset value", 8'h00, q)
        end
        wb(1'h0, 16'h7f50, 8'h00, 4'h1, q);
        `CHK("unmapped read", 8'h00, q)
        wb(1'h1, eiop_pkg::IDX_LATCH, 8'hff, 4'h0, q);
        wb(1'h0, eiop_pkg::IDX_LATCH, 8'h00, 4'h1, q);
        `CHK("lane off write", 8'h00, q)
        for (int it = 0; it < 40; it++) begin
            foreach (v[j]) v[j] = 8'($urandom);
            if (it < 4) for (int p = 0; p < 4; p++) {v[2][p], v[3][p], v[0][p], v[1][p]} = 4'(it * 4 + p);
            ta = 3'($urandom);
            av = {ta[0], ta[1], ta[2], 5'h00};
            for (int p = 0; p < 8; p++)
                {e_oe[p], e_o[p], e_pu[p], e_sl[p], e_iv[p]} = dec({v[2][p], v[3][p], v[0][p], v[1][p]},
                    p >= eiop_pkg::PIN_ALT_LO, av[p]);
            ext_en <= 8'($urandom) & e_oe;
            ext_val <= 8'($urandom);
            {tx, t6, t7} <= ta;
            for (int j = 0; j < 4; j++) wb(1'h1, idx[j], v[j], 4'h1, q);
            for (int j = 0; j < 4; j++) begin
                wb(1'h0, idx[j], 8'h00, 4'h1, q);
                `CHK("register", v[j], q)
            end
            `CHK("oe_n", e_oe, oe_n)
            `CHK("drive", e_o & ~e_oe, p_o & ~e_oe)
            `CHK("pull", e_pu, pu)
            `CHK("slow", e_sl, sl)
            k = ~e_oe | ext_en | e_pu;
            w = (~e_oe & e_o) | (e_oe & ext_en & ext_val) | (e_oe & ~ext_en & e_pu);
            repeat (6) @(posedge ref_clk);
            wb(1'h0, eiop_pkg::IDX_INPUT, 8'h00, 4'h1, q);
            `CHK("pin read", (w ^ e_iv) & k, q & k)
            `CHK("levels", w & k, lvl & k)
            `CHK("irqs", (w[3:0] ^ e_iv[3:0]) & k[3:0], irq & k[3:0])
            `CHK("serial rx", w[4] & k[4], rx & k[4])
        end
        sys_rst <= 1'h1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        for (int j = 0; j < 4; j++) begin
            wb(1'h0, idx[j], 8'h00, 4'h1, q);
            `CHK("reset again", 8'h00, q)
        end
        `CHK("pads idle", 8'hff, oe_n)
        `CHK("pulls idle", 8'h00, pu)
        give_verdict();
    end
endmodule
bind eiop_port eiop_port_monitor mon_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up), .pin_slow(pin_slow), .pin_level(pin_level), .serial_rx(serial_rx));
